/* logic/csp_pkg.sv */
/*
 * Shared constants and state types of the codec serial port framing block.
 * Assumes the codec master clock is the single 100 MHz logic clock.
 */
package csp_pkg;

   // ----------------------------------------------------------------
   // Word and clock division
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W    = 16;
   localparam int unsigned BIT_CNT_W = 4;
   localparam int unsigned MCLK_DIV  = 1;
   localparam int unsigned SCLK_DIV  = 8;
   localparam int unsigned SER_DIV   = MCLK_DIV * SCLK_DIV;
   localparam int unsigned HALF_DIV  = SER_DIV / 2;
   localparam int unsigned DIV_CNT_W = 3;

   localparam logic [DIV_CNT_W-1:0] DIV_RISE = DIV_CNT_W'(SER_DIV - 1);
   localparam logic [DIV_CNT_W-1:0] DIV_FALL = DIV_CNT_W'(HALF_DIV - 1);
   localparam logic [DIV_CNT_W-1:0] DIV_RST  = 3'h0;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(WORD_W - 1);
   localparam logic [BIT_CNT_W-1:0] BIT_RST  = 4'h0;
   localparam logic [WORD_W-1:0]    WORD_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Pin synchroniser layout
   // ----------------------------------------------------------------
   localparam int unsigned SYNC_W      = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;
   localparam int unsigned SYNC_SER_IN = 0;
   localparam int unsigned SYNC_IN_FS  = 1;
   localparam int unsigned SYNC_EN     = 2;
   localparam int unsigned SYNC_CRST_N = 3;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE  = 3'h1,
      TX_SYNC  = 3'h2,
      TX_SHIFT = 3'h4
   } csp_tx_st_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h1,
      RX_BITS = 2'h2
   } csp_rx_st_t;

endpackage : csp_pkg

/* logic/csp_pin_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to ref_clk_i.
 */
`timescale 1ns/1ps

module csp_pin_sync #(
   parameter int unsigned         WIDTH   = 4,
   parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_d;
   logic [WIDTH-1:0] out_q;

   // Output follows only once the second and third stages agree
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         out_q <= RST_VAL;
      end
      else
      begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_o = out_q;

endmodule : csp_pin_sync

/* logic/csp_serial_port.sv */
/*
 * Codec serial port framing: serial clock generation, output framing and
 * shifting, input framing and capture, and the asynchronous port enable.
 * Assumes ref_clk_i is the codec master clock and the host launches its
 * frame sync and data on the rising serial clock edge.
 */
`timescale 1ns/1ps

module csp_serial_port (
   input  wire logic                       ref_clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       codec_reset_n_i,
   input  wire logic                       port_enable_pin_i,
   input  wire logic                       ser_in_i,
   input  wire logic                       in_frame_sync_i,
   input  wire logic [csp_pkg::WORD_W-1:0] tx_word_i,
   input  wire logic                       tx_load_i,
   output logic                            sclk_o,
   output logic                            sclk_oe_o,
   output logic                            ser_out_o,
   output logic                            ser_out_oe_o,
   output logic                            out_frame_sync_o,
   output logic                            out_frame_sync_oe_o,
   output logic                            tx_pend_o,
   output logic [csp_pkg::WORD_W-1:0]      rx_word_o,
   output logic                            rx_valid_o
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [csp_pkg::SYNC_W-1:0] pins;
   logic [csp_pkg::SYNC_W-1:0] pins_s;
   logic                       en_s;
   logic                       crst;
   logic                       ser_in_s;
   logic                       in_fs_s;

   assign pins[csp_pkg::SYNC_SER_IN] = ser_in_i;
   assign pins[csp_pkg::SYNC_IN_FS]  = in_frame_sync_i;
   assign pins[csp_pkg::SYNC_EN]     = port_enable_pin_i;
   assign pins[csp_pkg::SYNC_CRST_N] = codec_reset_n_i;

   csp_pin_sync #(
      .WIDTH   (csp_pkg::SYNC_W),
      .RST_VAL (csp_pkg::SYNC_RST)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (pins),
      .sync_o    (pins_s)
   );

   assign crst     = ~pins_s[csp_pkg::SYNC_CRST_N];
   assign en_s     = pins_s[csp_pkg::SYNC_EN] & ~crst;
   assign ser_in_s = pins_s[csp_pkg::SYNC_SER_IN];
   assign in_fs_s  = pins_s[csp_pkg::SYNC_IN_FS];

   // ----------------------------------------------------------------
   // Serial clock generation
   // ----------------------------------------------------------------
   logic [csp_pkg::DIV_CNT_W-1:0] div_cnt_d, div_cnt_q;
   logic                          sclk_d, sclk_q;
   logic                          rise_evt;
   logic                          fall_evt;

   assign rise_evt = en_s && (div_cnt_q == csp_pkg::DIV_RISE);
   assign fall_evt = en_s && (div_cnt_q == csp_pkg::DIV_FALL);

   always_comb
   begin
      div_cnt_d = div_cnt_q;
      sclk_d    = sclk_q;
      if (!en_s)
      begin
         div_cnt_d = csp_pkg::DIV_RST;
         sclk_d    = 1'b0;
      end
      else
      begin
         div_cnt_d = rise_evt ? csp_pkg::DIV_RST : div_cnt_q + 3'h1;
         if (rise_evt)
            sclk_d = 1'b1;
         else if (fall_evt)
            sclk_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         div_cnt_q <= csp_pkg::DIV_RST;
         sclk_q    <= 1'b0;
      end
      else
      begin
         div_cnt_q <= div_cnt_d;
         sclk_q    <= sclk_d;
      end
   end

   // ----------------------------------------------------------------
   // Transmit framing and shifting
   // ----------------------------------------------------------------
   csp_pkg::csp_tx_st_t           tx_st_d, tx_st_q;
   logic [csp_pkg::WORD_W-1:0]    tx_data_d, tx_data_q;
   logic [csp_pkg::WORD_W-1:0]    shift_d, shift_q;
   logic [csp_pkg::BIT_CNT_W-1:0] tx_bit_d, tx_bit_q;
   logic                          pend_d, pend_q;
   logic                          fs_d, fs_q;
   logic                          ser_d, ser_q;
   logic                          ser_oe_d, ser_oe_q;
   logic                          en_q;

   always_comb
   begin
      tx_st_d   = tx_st_q;
      tx_data_d = tx_data_q;
      shift_d   = shift_q;
      tx_bit_d  = tx_bit_q;
      pend_d    = pend_q;
      fs_d      = fs_q;
      ser_d     = ser_q;
      ser_oe_d  = ser_oe_q;
      if (tx_load_i && !pend_q)
      begin
         tx_data_d = tx_word_i;
         pend_d    = 1'b1;
      end
      if (!en_s)
      begin
         tx_st_d  = csp_pkg::TX_IDLE;
         tx_bit_d = csp_pkg::BIT_RST;
         fs_d     = 1'b0;
         ser_d    = 1'b0;
         ser_oe_d = 1'b0;
      end
      else if (rise_evt)
      begin
         unique case (tx_st_q)
            csp_pkg::TX_IDLE:
            begin
               if (pend_q)
               begin
                  fs_d    = 1'b1;
                  shift_d = tx_data_q;
                  pend_d  = 1'b0;
                  tx_st_d = csp_pkg::TX_SYNC;
               end
            end
            csp_pkg::TX_SYNC:
            begin
               fs_d     = 1'b0;
               ser_d    = shift_q[csp_pkg::WORD_W-1];
               ser_oe_d = 1'b1;
               tx_bit_d = csp_pkg::BIT_RST;
               tx_st_d  = csp_pkg::TX_SHIFT;
            end
            csp_pkg::TX_SHIFT:
            begin
               if (tx_bit_q == csp_pkg::BIT_LAST)
               begin
                  ser_d    = 1'b0;
                  ser_oe_d = 1'b0;
                  tx_st_d  = csp_pkg::TX_IDLE;
                  if (pend_q)
                  begin
                     fs_d    = 1'b1;
                     shift_d = tx_data_q;
                     pend_d  = 1'b0;
                     tx_st_d = csp_pkg::TX_SYNC;
                  end
               end
               else
               begin
                  shift_d  = {shift_q[csp_pkg::WORD_W-2:0], 1'b0};
                  ser_d    = shift_q[csp_pkg::WORD_W-2];
                  tx_bit_d = tx_bit_q + 4'h1;
               end
            end
            default:
            begin
               tx_st_d = csp_pkg::TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tx_st_q   <= csp_pkg::TX_IDLE;
         tx_data_q <= csp_pkg::WORD_RST;
         shift_q   <= csp_pkg::WORD_RST;
         tx_bit_q  <= csp_pkg::BIT_RST;
         pend_q    <= 1'b0;
         fs_q      <= 1'b0;
         ser_q     <= 1'b0;
         ser_oe_q  <= 1'b0;
         en_q      <= 1'b0;
      end
      else if (crst)
      begin
         tx_st_q   <= csp_pkg::TX_IDLE;
         tx_data_q <= csp_pkg::WORD_RST;
         shift_q   <= csp_pkg::WORD_RST;
         tx_bit_q  <= csp_pkg::BIT_RST;
         pend_q    <= 1'b0;
         fs_q      <= 1'b0;
         ser_q     <= 1'b0;
         ser_oe_q  <= 1'b0;
         en_q      <= 1'b0;
      end
      else
      begin
         tx_st_q   <= tx_st_d;
         tx_data_q <= tx_data_d;
         shift_q   <= shift_d;
         tx_bit_q  <= tx_bit_d;
         pend_q    <= pend_d;
         fs_q      <= fs_d;
         ser_q     <= ser_d;
         ser_oe_q  <= ser_oe_d;
         en_q      <= en_s;
      end
   end

   // ----------------------------------------------------------------
   // Receive framing and capture
   // ----------------------------------------------------------------
   csp_pkg::csp_rx_st_t           rx_st_d, rx_st_q;
   logic [csp_pkg::WORD_W-1:0]    rx_sh_d, rx_sh_q;
   logic [csp_pkg::WORD_W-1:0]    rx_data_d, rx_data_q;
   logic [csp_pkg::BIT_CNT_W-1:0] rx_bit_d, rx_bit_q;
   logic                          rx_valid_d, rx_valid_q;

   always_comb
   begin
      rx_st_d    = rx_st_q;
      rx_sh_d    = rx_sh_q;
      rx_data_d  = rx_data_q;
      rx_bit_d   = rx_bit_q;
      rx_valid_d = 1'b0;
      if (!en_s)
      begin
         rx_st_d  = csp_pkg::RX_IDLE;
         rx_bit_d = csp_pkg::BIT_RST;
      end
      else if (fall_evt)
      begin
         unique case (rx_st_q)
            csp_pkg::RX_IDLE:
            begin
               if (in_fs_s)
               begin
                  rx_bit_d = csp_pkg::BIT_RST;
                  rx_st_d  = csp_pkg::RX_BITS;
               end
            end
            csp_pkg::RX_BITS:
            begin
               rx_sh_d  = {rx_sh_q[csp_pkg::WORD_W-2:0], ser_in_s};
               rx_bit_d = rx_bit_q + 4'h1;
               if (rx_bit_q == csp_pkg::BIT_LAST)
               begin
                  rx_data_d  = {rx_sh_q[csp_pkg::WORD_W-2:0], ser_in_s};
                  rx_valid_d = 1'b1;
                  rx_st_d    = csp_pkg::RX_IDLE;
               end
            end
            default:
            begin
               rx_st_d = csp_pkg::RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rx_st_q    <= csp_pkg::RX_IDLE;
         rx_sh_q    <= csp_pkg::WORD_RST;
         rx_data_q  <= csp_pkg::WORD_RST;
         rx_bit_q   <= csp_pkg::BIT_RST;
         rx_valid_q <= 1'b0;
      end
      else if (crst)
      begin
         rx_st_q    <= csp_pkg::RX_IDLE;
         rx_sh_q    <= csp_pkg::WORD_RST;
         rx_data_q  <= csp_pkg::WORD_RST;
         rx_bit_q   <= csp_pkg::BIT_RST;
         rx_valid_q <= 1'b0;
      end
      else
      begin
         rx_st_q    <= rx_st_d;
         rx_sh_q    <= rx_sh_d;
         rx_data_q  <= rx_data_d;
         rx_bit_q   <= rx_bit_d;
         rx_valid_q <= rx_valid_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sclk_o              = sclk_q;
   assign sclk_oe_o           = en_q;
   assign ser_out_o           = ser_q;
   assign ser_out_oe_o        = ser_oe_q;
   assign out_frame_sync_o    = fs_q;
   assign out_frame_sync_oe_o = en_q;
   assign tx_pend_o           = pend_q;
   assign rx_word_o           = rx_data_q;
   assign rx_valid_o          = rx_valid_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_fs_one_period: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i || !en_s)
      $rose(fs_q) |-> fs_q[*8] ##1 !fs_q && ser_oe_q) else $error("frame sync width wrong");
   a_fs_on_rise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(fs_q) |-> $rose(sclk_q)) else $error("frame sync not on rising edge");
   a_fs_hiz_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !en_s |=> !out_frame_sync_oe_o && !sclk_oe_o) else $error("outputs driven while off");
   a_rx_on_fall: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      rx_valid_q |-> $past(fall_evt) && !sclk_q) else $error("word not taken on falling edge");
   a_rx_ignored_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !en_s |=> !rx_valid_q && rx_st_q == csp_pkg::RX_IDLE) else $error("input not ignored");
   a_clk_stopped: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !en_s |=> !sclk_q && div_cnt_q == csp_pkg::DIV_RST) else $error("serial clock runs");
   a_sclk_period: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i || !en_s)
      $rose(sclk_q) |-> sclk_q[*4] ##1 !sclk_q[*4] ##1 sclk_q) else $error("serial clock period");
   a_ser_hiz_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      tx_st_q != csp_pkg::TX_SHIFT |-> !ser_oe_q) else $error("data driven while idle");
   a_data_kept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i || crst)
      $rose(en_s) |-> rx_data_q == $past(rx_data_q, 2)) else $error("word lost over disable");
   a_timing_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(en_s) |-> tx_st_q == csp_pkg::TX_IDLE && div_cnt_q == csp_pkg::DIV_RST
      && rx_st_q == csp_pkg::RX_IDLE && !fs_q) else $error("timing not restarted");

endmodule : csp_serial_port

/* verification/csp_host_model.sv */
/*
 * Host side of the codec serial port: sends input words with frame sync.
 * Assumes it sees the codec serial clock and drives on its rising edge.
 */
`timescale 1ns/1ps

module csp_host_model (
   input  wire logic ref_clk_i,
   input  wire logic sclk_i,
   output logic      in_frame_sync_o,
   output logic      ser_in_o
);

   initial
   begin
      in_frame_sync_o = 1'b0;
      ser_in_o        = 1'b0;
   end

   // Gap is one less than the number of serial clock rises waited before the frame sync
   task automatic send_word(input logic [csp_pkg::WORD_W-1:0] word, input int gap);
      repeat (gap) @(posedge sclk_i);
      @(posedge sclk_i);
      in_frame_sync_o = 1'b1;
      @(posedge sclk_i);
      in_frame_sync_o = 1'b0;
      for (int b = int'(csp_pkg::WORD_W) - 1; b >= 0; b--)
      begin
         ser_in_o = word[b];
         @(posedge sclk_i);
      end
      // Released line shows the inverse of the last bit
      ser_in_o = ~ser_in_o;
   endtask : send_word

   // Frame sync held high and data toggling regardless of the serial clock
   task automatic glitch(input int len);
      in_frame_sync_o = 1'b1;
      for (int i = 0; i < len; i++)
      begin
         @(negedge ref_clk_i);
         ser_in_o = ~ser_in_o;
      end
      in_frame_sync_o = 1'b0;
   endtask : glitch

endmodule : csp_host_model

/* verification/codec_serial_port_framing_bench.sv */
/*
 * Self-checking bench of the codec serial port framing block.
 * Assumes the host model drives the serial input and input frame sync pins and the bench the rest.
 */
`timescale 1ns/1ps

module codec_serial_port_framing_bench;
   localparam int W = csp_pkg::WORD_W;

   logic         ref_clk_i;
   logic         sys_rst_i;
   logic         codec_rst_n;
   logic         port_en;
   logic         tx_load;
   logic [W-1:0] tx_word;
   logic         sclk;
   logic         sclk_oe;
   logic         ser_out;
   logic         ser_out_oe;
   logic         ofs;
   logic         ofs_oe;
   logic         tx_pend;
   logic [W-1:0] rx_word;
   logic         rx_valid;
   logic         ser_in;
   logic         ifs;
   int           failures    = 0;
   int           checks_done = 0;
   int           cycles      = 0;

   csp_serial_port dut (
      .ref_clk_i          (ref_clk_i),
      .sys_rst_i          (sys_rst_i),
      .codec_reset_n_i    (codec_rst_n),
      .port_enable_pin_i  (port_en),
      .ser_in_i           (ser_in),
      .in_frame_sync_i    (ifs),
      .tx_word_i          (tx_word),
      .tx_load_i          (tx_load),
      .sclk_o             (sclk),
      .sclk_oe_o          (sclk_oe),
      .ser_out_o          (ser_out),
      .ser_out_oe_o       (ser_out_oe),
      .out_frame_sync_o   (ofs),
      .out_frame_sync_oe_o(ofs_oe),
      .tx_pend_o          (tx_pend),
      .rx_word_o          (rx_word),
      .rx_valid_o         (rx_valid)
   );

   csp_host_model host (
      .ref_clk_i      (ref_clk_i),
      .sclk_i         (sclk),
      .in_frame_sync_o(ifs),
      .ser_in_o       (ser_in)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit

   task automatic cmp_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_count(input string what, input int exp, input int got);
      checks_done++;
      if (got != exp)
      begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmp_count

   // ----------------------------------------------------------------
   // Shared drivers and monitors
   // ----------------------------------------------------------------
   task automatic load(input logic [W-1:0] word);
      @(negedge ref_clk_i);
      tx_word = word;
      tx_load = 1'b1;
      @(negedge ref_clk_i);
      tx_load = 1'b0;
   endtask : load

   task automatic expect_tx(input logic [W-1:0] word, input int max_wait, input logic last);
      int n;
      n = 0;
      while (ofs !== 1'b1 && n < max_wait)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      cmp_bit("frame sync seen", 1'b1, ofs);
      cmp_bit("sclk high at frame sync", 1'b1, sclk);
      cmp_bit("frame sync driven", 1'b1, ofs_oe);
      cmp_bit("sclk driven", 1'b1, sclk_oe);
      @(negedge sclk);
      @(negedge ref_clk_i);
      cmp_bit("data idle in sync period", 1'b0, ser_out_oe);
      for (int b = W - 1; b >= 0; b--)
      begin
         @(negedge sclk);
         @(negedge ref_clk_i);
         cmp_bit("frame sync width", 1'b0, ofs);
         cmp_bit("ser out drive", 1'b1, ser_out_oe);
         cmp_bit("ser out bit", word[b], ser_out);
      end
      if (last)
      begin
         @(posedge sclk);
         @(negedge ref_clk_i);
         cmp_bit("ser out released", 1'b0, ser_out_oe);
         cmp_bit("no frame sync after word", 1'b0, ofs);
      end
   endtask : expect_tx

   task automatic expect_rx(input logic [W-1:0] word);
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 400)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      cmp_bit("rx valid", 1'b1, rx_valid);
      cmp_word("rx word", word, rx_word);
      @(negedge ref_clk_i);
      cmp_bit("rx valid pulse", 1'b0, rx_valid);
   endtask : expect_rx

   task automatic quiet(input int len);
      int n;
      n = 0;
      repeat (len)
      begin
         @(negedge ref_clk_i);
         if (sclk !== 1'b0 || sclk_oe !== 1'b0 || ser_out_oe !== 1'b0 || ofs_oe !== 1'b0
             || rx_valid !== 1'b0)
            n++;
      end
      cmp_count("activity while disabled", 0, n);
   endtask : quiet

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_restart();
      int n;
      port_en = 1'b1;
      n = 0;
      while (sclk !== 1'b1 && n < 40)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      cmp_bit("first sclk rise in window", 1'b1, n >= 10 && n <= 14);
   endtask : t_restart

   task automatic t_rate();
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      @(posedge sclk);
      @(negedge ref_clk_i);
      while (sclk === 1'b1 && hi < 20)
      begin
         hi++;
         @(negedge ref_clk_i);
      end
      while (sclk === 1'b0 && lo < 20)
      begin
         lo++;
         @(negedge ref_clk_i);
      end
      cmp_count("sclk high clocks", csp_pkg::HALF_DIV, hi);
      cmp_count("sclk period clocks", csp_pkg::SER_DIV, hi + lo);
   endtask : t_rate

   task automatic t_duplex();
      int n;
      fork
         begin
            host.send_word(16'h9C36, 2);
            host.send_word(16'h5AA5, 0);
         end
         begin
            expect_rx(16'h9C36);
            expect_rx(16'h5AA5);
         end
         begin
            load(16'hA5C3);
            n = 0;
            while (tx_pend !== 1'b0 && n < 40)
            begin
               @(negedge ref_clk_i);
               n++;
            end
            load(16'h813E);
         end
         begin
            expect_tx(16'hA5C3, 40, 1'b0);
            expect_tx(16'h813E, 8, 1'b1);
         end
      join
   endtask : t_duplex

   task automatic t_disable();
      load(16'hF00D);
      repeat (60) @(negedge ref_clk_i);
      port_en = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      fork
         host.glitch(40);
         quiet(48);
      join
      t_restart();
      cmp_word("rx word kept", 16'h5AA5, rx_word);
      fork
         host.send_word(16'h0FF0, 1);
         expect_rx(16'h0FF0);
         begin
            load(16'hC0DE);
            expect_tx(16'hC0DE, 40, 1'b1);
         end
      join
   endtask : t_disable

   task automatic t_codec_reset();
      load(16'h3C3C);
      codec_rst_n = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      codec_rst_n = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      cmp_word("rx word after codec reset", 16'h0000, rx_word);
      cmp_bit("tx pending after codec reset", 1'b0, tx_pend);
      cmp_bit("ser out after codec reset", 1'b0, ser_out_oe);
   endtask : t_codec_reset

   initial
   begin
      sys_rst_i   = 1'b1;
      codec_rst_n = 1'b1;
      port_en     = 1'b0;
      tx_load     = 1'b0;
      tx_word     = '0;
      repeat (5) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      quiet(40);
      t_restart();
      t_rate();
      t_duplex();
      t_disable();
      t_codec_reset();
      conclude();
   end

endmodule : codec_serial_port_framing_bench
